// file: gsf_pkg.sv
/*
 * Shared constants for the status pin function selector: register map,
 * field widths, reset values, function codes and event bit positions.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package gsf_pkg;
    // Bus geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_FUNC = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_LEVEL = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_MASK = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_DIV = 5'h10;

    // Field widths and reset values
    localparam int FUNC_W = 5;
    localparam int DIV_W = 8;
    localparam int EVT_W = 8;
    localparam logic [FUNC_W-1:0] FUNC_RESET = 5'h00;
    localparam logic [DIV_W-1:0] DIV_RESET = 8'h03;
    localparam logic [EVT_W-1:0] MASK_RESET = 8'h00;

    // Pin function codes
    localparam logic [FUNC_W-1:0] CODE_LOOP2_LOCK = 5'h0A;
    localparam logic [FUNC_W-1:0] CODE_RATE1_LOCK = 5'h0B;
    localparam logic [FUNC_W-1:0] CODE_RATE2_LOCK = 5'h0C;
    localparam logic [FUNC_W-1:0] CODE_FIRST_AUDIO_INTERFACE_DETECT = 5'h0D;
    localparam logic [FUNC_W-1:0] CODE_SECOND_AUDIO_INTERFACE_DETECT = 5'h0F;
    localparam logic [FUNC_W-1:0] CODE_CORE_ERROR = 5'h11;
    localparam logic [FUNC_W-1:0] CODE_OPERATING_CLOCK_OUT = 5'h12;
    localparam logic [FUNC_W-1:0] CODE_TEMP_WARN = 5'h13;
    localparam logic [FUNC_W-1:0] CODE_SERVO_DONE = 5'h14;
    localparam logic [FUNC_W-1:0] CODE_LOOP1_CLK = 5'h15;

    // Event and level bit positions
    localparam int EVT_LOOP2_LOCK = 0;
    localparam int EVT_RATE1_LOCK = 1;
    localparam int EVT_RATE2_LOCK = 2;
    localparam int EVT_FIRST_AUDIO_INTERFACE_DETECT = 3;
    localparam int EVT_SECOND_AUDIO_INTERFACE_DETECT = 4;
    localparam int EVT_CORE_ERROR = 5;
    localparam int EVT_TEMP_WARN = 6;
    localparam int EVT_SERVO_DONE = 7;

    typedef enum logic {GSF_IDLE, GSF_ANSWER} gsf_bus_e;
endpackage

// file: gsf_clk_div.sv
/*
 * Enable divider for the operating clock output: one-cycle tick every
 * div+1 cycles while enabled. Assumes a single free-running clock.
 */
`timescale 1ns/100ps
`default_nettype none
module gsf_clk_div
    import gsf_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic enable,
    input wire logic [gsf_pkg::DIV_W-1:0] div,
    // Tick
    output logic tick
);
    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic tick_reg;
    logic tick_next;

    always_comb
    begin
        cnt_next = cnt_reg + 8'h01;
        tick_next = 1'b0;
        if (!enable)
        begin
            cnt_next = '0;
        end
        else if (cnt_reg >= div)
        begin
            // Compare with >= so a smaller divider takes effect at once
            cnt_next = '0;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule
`default_nettype wire

// file: gsf_irq.sv
/*
 * Sticky event status with write-one-to-clear, mask and one level
 * interrupt. Events are rising edges of the status levels.
 * Assumes levels synchronous to clk.
 */
`timescale 1ns/100ps
`default_nettype none
module gsf_irq
    import gsf_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Watched levels
    input wire logic [gsf_pkg::EVT_W-1:0] level,
    // Software access
    input wire logic clr_we,
    input wire logic [gsf_pkg::EVT_W-1:0] clr_data,
    input wire logic mask_we,
    input wire logic [gsf_pkg::EVT_W-1:0] mask_data,
    // State
    output logic [gsf_pkg::EVT_W-1:0] status,
    output logic [gsf_pkg::EVT_W-1:0] mask,
    output logic irq
);
    logic [EVT_W-1:0] prev_reg;
    logic [EVT_W-1:0] status_reg;
    logic [EVT_W-1:0] status_next;
    logic [EVT_W-1:0] mask_reg;
    logic [EVT_W-1:0] mask_next;
    logic irq_reg;
    logic irq_next;

    // A set in the clearing cycle wins, so no event is lost
    genvar i;
    generate
        for (i = 0; i < EVT_W; i++)
        begin : g_bit
            assign status_next[i] = (level[i] & ~prev_reg[i])
                | (status_reg[i] & ~(clr_we & clr_data[i]));
        end
    endgenerate

    always_comb
    begin
        mask_next = mask_we ? mask_data : mask_reg;
        irq_next = |(status_next & mask_next);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_reg <= '0;
            status_reg <= '0;
            mask_reg <= MASK_RESET;
            irq_reg <= 1'b0;
        end
        else
        begin
            prev_reg <= level;
            status_reg <= status_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
        end
    end

    assign status = status_reg;
    assign mask = mask_reg;
    assign irq = irq_reg;
endmodule
`default_nettype wire

// file: gsf_top.sv
/*
 * Status pin function selector: a function code picks which status flag
 * or clock drives the general-purpose pin, with an Avalon-MM register
 * slave and an event interrupt.
 * Assumes all status inputs are synchronous to clk (40 MHz).
 */
// Operation
// - Code 0Ah: second loop lock on pin
// - Code 0Bh: first rate converter lock
// - Code 0Ch: second rate converter lock
// - Code 0Dh: first interface level detect
// - Code 0Fh: second interface level detect
// - Code 11h: core buffer error flag
// - Code 12h: divided operating clock out
// - Code 13h: temperature warning flag
// - Code 14h: high once both servos done
// - Code 15h: first loop clock out
`timescale 1ns/100ps
`default_nettype none
module gsf_top
    import gsf_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [gsf_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [gsf_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [gsf_pkg::BE_W-1:0] avs_byteenable,
    output logic [gsf_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Status sources
    input wire logic second_locked_loop_lock,
    input wire logic first_rate_converter_lock,
    input wire logic second_rate_converter_lock,
    input wire logic first_audio_interface_detect,
    input wire logic second_audio_interface_detect,
    input wire logic core_error,
    input wire logic temp_warning,
    input wire logic headphone_left_output_done,
    input wire logic headphone_right_output_done,
    input wire logic first_locked_loop_clk,
    // Pin and interrupt
    output logic gpio_pin,
    output logic irq
);
    // Bus handshake
    gsf_bus_e bus_reg;
    gsf_bus_e bus_next;
    logic wait_reg;
    logic wait_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;

    // Configuration
    logic [FUNC_W-1:0] func_reg;
    logic [FUNC_W-1:0] func_next;
    logic [DIV_W-1:0] div_reg;
    logic [DIV_W-1:0] div_next;

    // Pin path
    logic operating_clock_out_reg;
    logic operating_clock_out_next;
    logic pin_reg;
    logic pin_next;
    logic operating_clock_out_tick;
    logic servo_done;

    // Interrupt side
    logic [EVT_W-1:0] levels;
    logic [EVT_W-1:0] evt_status;
    logic [EVT_W-1:0] evt_mask;
    logic take_write;
    logic low_lane;
    logic clr_we;
    logic mask_we;
    logic irq_int;

    assign servo_done = headphone_left_output_done
        & headphone_right_output_done;

    always_comb
    begin
        levels = '0;
        levels[EVT_LOOP2_LOCK] = second_locked_loop_lock;
        levels[EVT_RATE1_LOCK] = first_rate_converter_lock;
        levels[EVT_RATE2_LOCK] = second_rate_converter_lock;
        levels[EVT_FIRST_AUDIO_INTERFACE_DETECT] = first_audio_interface_detect;
        levels[EVT_SECOND_AUDIO_INTERFACE_DETECT] = second_audio_interface_detect;
        levels[EVT_CORE_ERROR] = core_error;
        levels[EVT_TEMP_WARN] = temp_warning;
        levels[EVT_SERVO_DONE] = servo_done;
    end

    // A write lands only at the edge where waitrequest is seen low
    assign take_write = (bus_reg == GSF_ANSWER) && avs_write;
    assign low_lane = take_write && avs_byteenable[0];
    assign clr_we = low_lane && (avs_address == OFS_STATUS);
    assign mask_we = low_lane && (avs_address == OFS_MASK);

    always_comb
    begin
        bus_next = bus_reg;
        wait_next = 1'b1;
        rdata_next = rdata_reg;
        case (bus_reg)
            GSF_IDLE:
            begin
                if (avs_read || avs_write)
                begin
                    bus_next = GSF_ANSWER;
                    wait_next = 1'b0;
                    rdata_next = '0;
                    if (avs_read)
                    begin
                        case (avs_address)
                            OFS_FUNC: rdata_next[FUNC_W-1:0] = func_reg;
                            OFS_LEVEL: rdata_next[EVT_W-1:0] = levels;
                            OFS_STATUS: rdata_next[EVT_W-1:0] = evt_status;
                            OFS_MASK: rdata_next[EVT_W-1:0] = evt_mask;
                            OFS_DIV: rdata_next[DIV_W-1:0] = div_reg;
                            default: rdata_next = '0;
                        endcase
                    end
                end
            end
            GSF_ANSWER:
            begin
                // One idle cycle between answers keeps a held request from
                // being taken twice
                bus_next = GSF_IDLE;
            end
            default:
            begin
                bus_next = GSF_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_reg <= GSF_IDLE;
            wait_reg <= 1'b1;
            rdata_reg <= '0;
        end
        else
        begin
            bus_reg <= bus_next;
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    always_comb
    begin
        func_next = func_reg;
        div_next = div_reg;
        if (low_lane && (avs_address == OFS_FUNC))
        begin
            func_next = avs_writedata[FUNC_W-1:0];
        end
        if (low_lane && (avs_address == OFS_DIV))
        begin
            div_next = avs_writedata[DIV_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            func_reg <= FUNC_RESET;
            div_reg <= DIV_RESET;
        end
        else
        begin
            func_reg <= func_next;
            div_reg <= div_next;
        end
    end

    // Divider only runs while its output is selected, to save power
    gsf_clk_div u_div (
        .clk(clk),
        .rst_n(rst_n),
        .enable(func_reg == CODE_OPERATING_CLOCK_OUT),
        .div(div_reg),
        .tick(operating_clock_out_tick)
    );

    always_comb
    begin
        operating_clock_out_next = operating_clock_out_reg;
        if (func_reg != CODE_OPERATING_CLOCK_OUT)
        begin
            operating_clock_out_next = 1'b0;
        end
        else if (operating_clock_out_tick)
        begin
            operating_clock_out_next = ~operating_clock_out_reg;
        end
    end

    // Registered mux: one cycle of latency on every source, the loop
    // clock included, keeps the pin free of glitches
    always_comb
    begin
        case (func_reg)
            CODE_LOOP2_LOCK: pin_next = second_locked_loop_lock;
            CODE_RATE1_LOCK: pin_next = first_rate_converter_lock;
            CODE_RATE2_LOCK: pin_next = second_rate_converter_lock;
            CODE_FIRST_AUDIO_INTERFACE_DETECT: pin_next = first_audio_interface_detect;
            CODE_SECOND_AUDIO_INTERFACE_DETECT: pin_next = second_audio_interface_detect;
            CODE_CORE_ERROR: pin_next = core_error;
            CODE_OPERATING_CLOCK_OUT: pin_next = operating_clock_out_reg;
            CODE_TEMP_WARN: pin_next = temp_warning;
            CODE_SERVO_DONE: pin_next = servo_done;
            CODE_LOOP1_CLK: pin_next = first_locked_loop_clk;
            default: pin_next = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            operating_clock_out_reg <= 1'b0;
            pin_reg <= 1'b0;
        end
        else
        begin
            operating_clock_out_reg <= operating_clock_out_next;
            pin_reg <= pin_next;
        end
    end

    gsf_irq u_irq (
        .clk(clk),
        .rst_n(rst_n),
        .level(levels),
        .clr_we(clr_we),
        .clr_data(avs_writedata[EVT_W-1:0]),
        .mask_we(mask_we),
        .mask_data(avs_writedata[EVT_W-1:0]),
        .status(evt_status),
        .mask(evt_mask),
        .irq(irq_int)
    );

    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign gpio_pin = pin_reg;
    assign irq = irq_int;

    a_loop2_lock: assert property (@(posedge clk) disable iff (!rst_n)
        (func_reg == CODE_LOOP2_LOCK) |=> (gpio_pin == $past(second_locked_loop_lock)))
        else $error("pin does not follow second loop lock");

    a_rate1_lock: assert property (@(posedge clk) disable iff (!rst_n)
        (func_reg == CODE_RATE1_LOCK) && first_rate_converter_lock |=> gpio_pin)
        else $error("pin low while first converter locked");

    a_rate1_unlock: assert property (@(posedge clk) disable iff (!rst_n)
        (func_reg == CODE_RATE1_LOCK) && !first_rate_converter_lock |=> !gpio_pin)
        else $error("pin high while first converter unlocked");

    a_rate2_lock: assert property (@(posedge clk) disable iff (!rst_n)
        (func_reg == CODE_RATE2_LOCK) |=> (gpio_pin == $past(second_rate_converter_lock)))
        else $error("pin does not follow second converter lock");

    a_first_audio_interface_detect: assert property (@(posedge clk) disable iff (!rst_n)
        (func_reg == CODE_FIRST_AUDIO_INTERFACE_DETECT) |=> (gpio_pin == $past(first_audio_interface_detect)))
        else $error("pin does not follow first interface detect");

    a_second_audio_interface_detect: assert property (@(posedge clk) disable iff (!rst_n)
        (func_reg == CODE_SECOND_AUDIO_INTERFACE_DETECT) |=> (gpio_pin == $past(second_audio_interface_detect)))
        else $error("pin does not follow second interface detect");

    a_core_error: assert property (@(posedge clk) disable iff (!rst_n)
        (func_reg == CODE_CORE_ERROR) |=> (gpio_pin == $past(core_error)))
        else $error("pin does not follow core error");

    a_operating_clock_out_toggle: assert property (@(posedge clk) disable iff (!rst_n)
        (func_reg == CODE_OPERATING_CLOCK_OUT) && operating_clock_out_tick ##1 (func_reg == CODE_OPERATING_CLOCK_OUT)
        |=> (gpio_pin != $past(gpio_pin)))
        else $error("operating clock did not toggle on the pin");

    a_operating_clock_out_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (func_reg != CODE_OPERATING_CLOCK_OUT) |=> !operating_clock_out_reg)
        else $error("operating clock runs while not selected");

    a_temp_warn: assert property (@(posedge clk) disable iff (!rst_n)
        (func_reg == CODE_TEMP_WARN) |=> (gpio_pin == $past(temp_warning)))
        else $error("pin does not follow temperature warning");

    a_servo_done: assert property (@(posedge clk) disable iff (!rst_n)
        (func_reg == CODE_SERVO_DONE) && !(headphone_left_output_done
        && headphone_right_output_done) |=> !gpio_pin)
        else $error("pin high before both servos done");

    a_loop1_clk: assert property (@(posedge clk) disable iff (!rst_n)
        (func_reg == CODE_LOOP1_CLK) |=> (gpio_pin == $past(first_locked_loop_clk)))
        else $error("pin does not follow first loop clock");

    a_reserved_low: assert property (@(posedge clk) disable iff (!rst_n)
        (func_reg == 5'h0E) || (func_reg == 5'h10) || (func_reg < CODE_LOOP2_LOCK)
        || (func_reg > CODE_LOOP1_CLK) |=> !gpio_pin)
        else $error("reserved code drives the pin");

    a_wait_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

    a_bus_answer: assert property (@(posedge clk) disable iff (!rst_n)
        avs_waitrequest && (avs_read || avs_write) && (bus_reg == GSF_IDLE)
        |=> !avs_waitrequest)
        else $error("request not answered in one cycle");

    a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
        |(evt_status & evt_mask) |-> irq)
        else $error("interrupt low with unmasked status set");

    a_servo_high: assert property (@(posedge clk) disable iff (!rst_n)
        (func_reg == CODE_SERVO_DONE) && headphone_left_output_done
        && headphone_right_output_done |=> gpio_pin)
        else $error("pin low after both servos done");

    a_func_write: assert property (@(posedge clk) disable iff (!rst_n)
        low_lane && (avs_address == OFS_FUNC) |=> (func_reg == $past(avs_writedata[FUNC_W-1:0])))
        else $error("function write did not land");

    a_div_write: assert property (@(posedge clk) disable iff (!rst_n)
        low_lane && (avs_address == OFS_DIV) |=> (div_reg == $past(avs_writedata[DIV_W-1:0])))
        else $error("divider write did not land");

    a_wait_idle: assert property (@(posedge clk) disable iff (!rst_n)
        (bus_reg == GSF_IDLE) |-> avs_waitrequest)
        else $error("waitrequest low while the slave is idle");
endmodule
`default_nettype wire

// file: gsf_host_model.sv
/*
 * Host-side monitor of the status pin: brings the pin into the host clock
 * and counts its rising edges as the host sees them.
 * Assumes the host runs on the bench clock and reads the pin as a level.
 */
`timescale 1ns/100ps
`default_nettype none
module gsf_host_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Watched pin
    input wire logic gpio_pin,
    // Host view
    output logic pin_sync,
    output logic [15:0] rise_count
);
    logic [2:0] sync_reg;

    // Three flops, since the pin may change at any time; its pulses last at least one clk cycle, as it comes from a flop;
    // the edge is taken behind the second flop so a metastable first stage is never read
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_reg <= 3'h0;
            rise_count <= 16'h0000;
        end
        else
        begin
            sync_reg <= {sync_reg[1:0], gpio_pin};
            if (sync_reg[2:1] == 2'h1)
                rise_count <= rise_count + 16'h0001;
        end
    end

    assign pin_sync = sync_reg[1];
endmodule
`default_nettype wire

// file: testbench.sv
/*
 * Self-checking bench for the status pin selector: register access over
 * Avalon-MM, every pin function, reserved codes, clocks and the interrupt.
 * Assumes gsf_pkg, gsf_top and gsf_host_model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import gsf_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [DATA_W-1:0] avs_writedata = 32'h00000000;
    logic [BE_W-1:0] avs_byteenable = 4'hF;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic [EVT_W-1:0] src = 8'h00;
    logic left_only = 1'b0;
    logic lclk = 1'b0;
    logic lclk_run = 1'b0;
    logic gpio_pin;
    logic irq;
    logic pin_sync;
    logic [15:0] rise_count;
    int errors = 0;
    int n_tests = 0;
    logic [FUNC_W-1:0] codes [8] = '{CODE_LOOP2_LOCK, CODE_RATE1_LOCK, CODE_RATE2_LOCK, CODE_FIRST_AUDIO_INTERFACE_DETECT,
        CODE_SECOND_AUDIO_INTERFACE_DETECT, CODE_CORE_ERROR, CODE_TEMP_WARN, CODE_SERVO_DONE};
    int divs [3] = '{3, 0, 5};

    always #12.5 clk = ~clk;

    always @(posedge clk)
        if (lclk_run)
            lclk <= ~lclk;

    gsf_top dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .second_locked_loop_lock(src[EVT_LOOP2_LOCK]), .first_rate_converter_lock(src[EVT_RATE1_LOCK]),
        .second_rate_converter_lock(src[EVT_RATE2_LOCK]), .first_audio_interface_detect(src[EVT_FIRST_AUDIO_INTERFACE_DETECT]),
        .second_audio_interface_detect(src[EVT_SECOND_AUDIO_INTERFACE_DETECT]), .core_error(src[EVT_CORE_ERROR]),
        .temp_warning(src[EVT_TEMP_WARN]), .headphone_left_output_done(src[EVT_SERVO_DONE] | left_only),
        .headphone_right_output_done(src[EVT_SERVO_DONE]), .first_locked_loop_clk(lclk),
        .gpio_pin(gpio_pin), .irq(irq));

    gsf_host_model host (.clk(clk), .rst_n(rst_n), .gpio_pin(gpio_pin), .pin_sync(pin_sync),
        .rise_count(rise_count));

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] got);
        n_tests++;
        if (got !== e)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, e, got);
        end
    endtask

    task automatic pin_is(input logic e);
        check("gpio_pin", {31'h0, e}, {31'h0, gpio_pin});
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Entered just after a rising edge; holds the request until waitrequest is seen low
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int i;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        for (i = 0; i < 50; i++)
        begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        if (i == 50)
        begin
            errors++;
            give_verdict();
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h00000000, q);
        check(what, e, q);
    endtask

    // Cycles between host-seen rises; the first two gaps only align to the waveform, the third is returned
    task automatic rise_gap(output int p);
        logic [15:0] r;
        int i;
        // Let a divider change and the host pipeline settle before measuring
        wait_cyc(30);
        for (i = 0; i < 3; i++)
        begin
            r = rise_count;
            p = 0;
            while (rise_count === r && p < 100)
            begin
                @(posedge clk);
                p++;
            end
        end
        if (p >= 100)
        begin
            errors++;
            give_verdict();
        end
    endtask

    initial
    begin
        int k;
        int c;
        int p;
        logic prev;
        wait_cyc(12);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(OFS_FUNC, 32'h00000000, "func reset");
        rd(OFS_DIV, 32'h00000003, "div reset");
        avs_byteenable <= 4'hE;
        wr(OFS_DIV, 32'h00000007);
        avs_byteenable <= 4'hF;
        rd(OFS_DIV, 32'h00000003, "div lane off");
        rd(OFS_MASK, 32'h00000000, "mask reset");
        rd(OFS_STATUS, 32'h00000000, "status reset");
        rd(5'h14, 32'h00000000, "unmapped read");
        pin_is(1'b0);
        $display("Test reset values done");

        for (k = 0; k < 8; k++)
        begin
            wr(OFS_FUNC, {27'h0, codes[k]});
            src <= 8'h00;
            wait_cyc(3);
            pin_is(1'b0);
            src <= 8'h01 << k;
            wait_cyc(3);
            pin_is(1'b1);
            wait_cyc(2);
            check("pin_sync", 32'h00000001, {31'h0, pin_sync});
            src <= ~(8'h01 << k);
            left_only <= (k == EVT_SERVO_DONE);
            wait_cyc(3);
            pin_is(1'b0);
            left_only <= 1'b0;
        end
        $display("Test status selections done");

        src <= 8'hFF;
        lclk_run <= 1'b1;
        for (c = 0; c < 32; c++)
        begin
            if (c < 10 || c == 14 || c == 16 || c > 21)
            begin
                wr(OFS_FUNC, c);
                for (k = 0; k < 4; k++)
                begin
                    @(posedge clk);
                    pin_is(1'b0);
                end
            end
        end
        $display("Test reserved codes done");

        wr(OFS_FUNC, {27'h0, CODE_LOOP1_CLK});
        wait_cyc(3);
        prev = lclk;
        for (k = 0; k < 6; k++)
        begin
            @(posedge clk);
            pin_is(prev);
            prev = lclk;
        end
        $display("Test loop clock done");

        src <= 8'h00;
        wr(OFS_FUNC, {27'h0, CODE_OPERATING_CLOCK_OUT});
        for (k = 0; k < 3; k++)
        begin
            wr(OFS_DIV, divs[k]);
            rise_gap(p);
            check("operating_clock_out period", 2 * (divs[k] + 1), p);
        end
        $display("Test operating clock done");

        lclk_run <= 1'b0;
        src <= 8'hA5;
        wait_cyc(3);
        rd(OFS_LEVEL, 32'h000000A5, "level");
        src <= 8'h00;
        wr(OFS_MASK, 32'h00000000);
        wr(OFS_STATUS, 32'h000000FF);
        rd(OFS_STATUS, 32'h00000000, "status cleared");
        src <= 8'h01 << EVT_TEMP_WARN;
        wait_cyc(3);
        rd(OFS_STATUS, 32'h00000040, "status temp");
        check("irq masked", 32'h0, {31'h0, irq});
        wr(OFS_MASK, 32'h00000040);
        src <= 8'h00;
        wait_cyc(2);
        check("irq pending", 32'h1, {31'h0, irq});
        wr(OFS_STATUS, 32'h00000040);
        wait_cyc(2);
        check("irq cleared", 32'h0, {31'h0, irq});
        rd(OFS_STATUS, 32'h00000000, "status after clear");
        $display("Test interrupt done");
        give_verdict();
    end
endmodule
`default_nettype wire
